// File: sticky_flags.sv
`timescale 1ns/1ps
`default_nettype none
module sticky_flags #(
    parameter int N = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [N-1:0] set,
    input  wire logic [N-1:0] clr,
    input  wire logic [N-1:0] enable,
    output logic      [N-1:0] status,
    output logic              irq
);
    logic [N-1:0] next_status;

    // set beats clear so an event in the clearing cycle survives
    assign next_status = (status & ~clr) | set;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status <= '0;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            irq    <= |(next_status & enable);
        end
    end
endmodule
`default_nettype wire

// File: tick_divider.sv
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
    parameter int unsigned DIV = 12
) (
    input  wire logic clk,
    input  wire logic rst_b,
    output logic      tick
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt;

    // free running, one-cycle enable every DIV clocks
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else if (cnt == LAST) begin
            cnt  <= '0;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: watchdog_interval_timer.sv
// Contract
// - with reset generation off, underflow raises only the interrupt, no reset
// - in either slow power mode only the sysclk/12 tick counts
// - turn-on code 01 freezes counting; the counter holds its value
// - turn-on code 10 runs the 8-bit counter downward
// - turn-on codes 00 and 11 run the counter exactly like 10
// - reset-enable code 01 means underflow never requests a chip reset
// - reset-enable code 10 makes underflow request a chip reset
// - reset-enable codes 00 and 11 request a chip reset like 10
// - control bit 3 is read-only: 0 after pin reset, 1 after watchdog reset
// - control bits 1:0 pick the counting clock; bit 2 reads zero
// - counter is 8 bits, read/write, resets to ff, hardware updates it
// - underflow comes after counter value plus one selected-clock periods
// - every underflow sets the interrupt flag; servicing clears it
// - the clock select picks one of four counting sources
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module watchdog_interval_timer
    import wdt_pkg::*;
#(
    parameter int unsigned DIV_SRC0        = 12,
    parameter int unsigned DIV_SRC1        = 48,
    parameter int unsigned DIV_SRC2        = 192,
    parameter int unsigned DIV_SRC3        = 768,
    parameter int unsigned CHIP_RESET_LEN  = CHIP_RESET_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        pin_rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        all_slow_power_mode,
    input  wire logic        peripheral_slow_power_mode,
    input  wire logic        irq_ack,
    output logic             irq,
    output logic             chip_reset_req
);
    localparam int unsigned DIVS [4] = '{DIV_SRC0, DIV_SRC1, DIV_SRC2,
                                         DIV_SRC3};
    localparam int FW = (CHIP_RESET_LEN > 1) ? $clog2(CHIP_RESET_LEN) : 1;
    localparam logic [FW-1:0] FIRE_LAST = FW'(CHIP_RESET_LEN - 1);

    // a two-bit field counts as on unless it holds exactly the off code
    function automatic logic field_active(input logic [1:0] code);
        field_active = (code != FIELD_OFF);
    endfunction

    logic [1:0]          turn_on_field;
    logic [1:0]          reset_enable_field;
    logic [1:0]          count_clock_select;
    logic                reset_source_flag;
    logic [7:0]          watchdog_counter;
    logic [IRQ_BITS-1:0] irq_enable;
    logic [IRQ_BITS-1:0] underflow_irq_flag;
    fire_state_t         fire_state;
    fire_state_t         next_fire_state;
    logic [FW-1:0]       fire_cnt;
    logic [3:0]          src_tick;
    logic                slow_tick;

    // apb decode
    wire setup_phase  = psel && !penable;
    wire access_phase = psel && penable;
    wire wr_access    = access_phase && pwrite;
    wire hit_ctrl     = (paddr == CTRL_OFS);
    wire hit_cnt      = (paddr == CNT_OFS);
    wire hit_stat     = (paddr == IRQ_STAT_OFS);
    wire hit_clr      = (paddr == IRQ_CLR_OFS);
    wire hit_en       = (paddr == IRQ_EN_OFS);
    wire mapped       = hit_ctrl || hit_cnt || hit_stat || hit_clr || hit_en;
    wire ctrl_wr      = wr_access && hit_ctrl;
    wire cnt_wr       = wr_access && hit_cnt;
    wire clr_wr       = wr_access && hit_clr;
    wire en_wr        = wr_access && hit_en;

    // zero wait states; unmapped offsets answer with an error
    assign pready  = 1'b1;
    assign pslverr = access_phase && !mapped;

    // four counting sources, each a divided system clock
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_src
            tick_divider #(
                .DIV (DIVS[g])
            ) u_div (
                .clk   (clk),
                .rst_b (rst_b),
                .tick  (src_tick[g])
            );
        end
    endgenerate

    // dedicated divide-by-twelve used in slow modes
    tick_divider #(
        .DIV (SLOW_DIV)
    ) u_slow_div (
        .clk   (clk),
        .rst_b (rst_b),
        .tick  (slow_tick)
    );

    // source choice; slow modes override whatever software selected
    wire slow_mode  = all_slow_power_mode || peripheral_slow_power_mode;
    wire sel_tick   = src_tick[count_clock_select];
    wire count_tick = slow_mode ? slow_tick : sel_tick;

    // counter control
    wire running    = field_active(turn_on_field);
    wire reset_gen  = field_active(reset_enable_field);
    wire step       = count_tick && running;
    // a same-cycle reload wins, so a last-moment kick still saves the chip
    wire underflow  = step && (watchdog_counter == CNT_ZERO) && !cnt_wr;
    wire fire       = underflow && reset_gen && (fire_state == WD_IDLE);

    // decrement wraps 00 to ff, so the next interval starts at ff
    wire [7:0] next_counter = cnt_wr ? pwdata[7:0] :
                              step   ? watchdog_counter - 8'h01 :
                                       watchdog_counter;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            watchdog_counter <= CNT_RST;
        end else begin
            watchdog_counter <= next_counter;
        end
    end

    // control register and interrupt enable, written in the access phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            turn_on_field      <= TURN_ON_RST;
            reset_enable_field <= RESET_EN_RST;
            count_clock_select <= CLK_SEL_RST;
            irq_enable         <= IRQ_EN_RST;
        end else begin
            if (ctrl_wr) begin
                turn_on_field      <= pwdata[TURN_ON_LSB +: 2];
                reset_enable_field <= pwdata[RESET_EN_LSB +: 2];
                count_clock_select <= pwdata[CLK_SEL_LSB +: 2];
            end
            if (en_wr) begin
                irq_enable <= pwdata[IRQ_BITS-1:0];
            end
        end
    end

    // reset source flag lives on the pin reset so the chip reset that a
    // watchdog underflow causes does not wipe it
    always_ff @(posedge clk or negedge pin_rst_b) begin
        if (!pin_rst_b) begin
            reset_source_flag <= 1'b0;
        end else if (fire) begin
            reset_source_flag <= 1'b1;
        end
    end

    // chip reset request: fixed-length pulse, then back to idle
    always_comb begin
        next_fire_state = fire_state;
        case (fire_state)
            WD_IDLE: begin
                if (fire) begin
                    next_fire_state = WD_FIRE;
                end
            end
            WD_FIRE: begin
                if (fire_cnt == FIRE_LAST) begin
                    next_fire_state = WD_IDLE;
                end
            end
            default: begin
                next_fire_state = WD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fire_state     <= WD_IDLE;
            fire_cnt       <= '0;
            chip_reset_req <= 1'b0;
        end else begin
            fire_state     <= next_fire_state;
            fire_cnt       <= (fire_state == WD_FIRE) ? fire_cnt + 1'b1 : '0;
            chip_reset_req <= (next_fire_state == WD_FIRE);
        end
    end

    // sticky underflow flag; servicing or a software clear drops it
    wire [IRQ_BITS-1:0] irq_set = underflow;
    wire [IRQ_BITS-1:0] irq_clr = (clr_wr ? pwdata[IRQ_BITS-1:0] : '0) |
                                  {IRQ_BITS{irq_ack}};

    sticky_flags #(
        .N (IRQ_BITS)
    ) u_flags (
        .clk    (clk),
        .rst_b  (rst_b),
        .set    (irq_set),
        .clr    (irq_clr),
        .enable (irq_enable),
        .status (underflow_irq_flag),
        .irq    (irq)
    );

    // read mux; the clear register reads as zero
    wire [7:0]  ctrl_word = {turn_on_field, reset_enable_field,
                             reset_source_flag, 1'b0,
                             count_clock_select};
    wire [31:0] rd_word   = hit_ctrl ? {24'h0, ctrl_word} :
                            hit_cnt  ? {24'h0, watchdog_counter} :
                            hit_stat ? {{(32-IRQ_BITS){1'b0}},
                                        underflow_irq_flag} :
                            hit_en   ? {{(32-IRQ_BITS){1'b0}}, irq_enable} :
                                       32'h0;

    // snapshot in the setup cycle so data is a flop in the access phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0;
        end else if (setup_phase && !pwrite) begin
            prdata <= rd_word;
        end
    end

    // checks next to the logic they guard
    property p_irq_on_underflow;
        @(posedge clk) disable iff (!rst_b)
        underflow |=> underflow_irq_flag[0];
    endproperty
    a_irq_on_underflow: assert property (p_irq_on_underflow)
        else $error("underflow did not set the interrupt flag");

    property p_reset_on_underflow;
        @(posedge clk) disable iff (!rst_b)
        (underflow && reset_gen && fire_state == WD_IDLE) |=> chip_reset_req;
    endproperty
    a_reset_on_underflow: assert property (p_reset_on_underflow)
        else $error("enabled underflow gave no chip reset request");

    property p_no_reset_when_off;
        @(posedge clk) disable iff (!rst_b)
        (!reset_gen && !chip_reset_req) |=> !chip_reset_req;
    endproperty
    a_no_reset_when_off: assert property (p_no_reset_when_off)
        else $error("chip reset requested with reset generation off");

    property p_pulse_len;
        @(posedge clk) disable iff (!rst_b)
        $rose(chip_reset_req) |-> chip_reset_req [*2] ##[0:300]
            !chip_reset_req;
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("chip reset pulse wrong length");

    property p_hold_when_off;
        @(posedge clk) disable iff (!rst_b)
        (turn_on_field == FIELD_OFF && !cnt_wr) |=>
            (watchdog_counter == $past(watchdog_counter));
    endproperty
    a_hold_when_off: assert property (p_hold_when_off)
        else $error("counter moved while turned off");

    property p_decrement;
        @(posedge clk) disable iff (!rst_b)
        (step && !cnt_wr) |=>
            (watchdog_counter == $past(watchdog_counter) - 8'h01);
    endproperty
    a_decrement: assert property (p_decrement)
        else $error("running counter did not step down by one");

    property p_slow_source;
        @(posedge clk) disable iff (!rst_b)
        (slow_mode && !slow_tick && !cnt_wr) |=> $stable(watchdog_counter);
    endproperty
    a_slow_source: assert property (p_slow_source)
        else $error("slow mode counted on a source other than div twelve");

    property p_source_flag;
        @(posedge clk) disable iff (!rst_b || !pin_rst_b)
        fire |=> reset_source_flag;
    endproperty
    a_source_flag: assert property (p_source_flag)
        else $error("watchdog reset did not mark the reset source");

    property p_reload;
        @(posedge clk) disable iff (!rst_b)
        cnt_wr |=> (watchdog_counter == $past(pwdata[7:0]));
    endproperty
    a_reload: assert property (p_reload)
        else $error("counter write was not loaded");

    property p_ctrl_read;
        @(posedge clk) disable iff (!rst_b)
        (setup_phase && !pwrite && hit_ctrl) |=>
            (prdata[RSVD_BIT] == 1'b0 &&
             prdata[1:0] == $past(count_clock_select));
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("control read shows wrong select or reserved bit");

    // interval timer mode must still reach the interrupt line
    property p_irq_level;
        @(posedge clk) disable iff (!rst_b)
        (underflow && irq_enable[0]) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("enabled underflow did not raise the interrupt");

    property p_ack_clear;
        @(posedge clk) disable iff (!rst_b)
        (irq_ack && !underflow) |=> !underflow_irq_flag[0];
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("servicing did not clear the interrupt flag");

    // only the chosen source may move the counter outside slow modes
    property p_select_source;
        @(posedge clk) disable iff (!rst_b)
        (!slow_mode && !src_tick[count_clock_select] && !cnt_wr) |=>
            $stable(watchdog_counter);
    endproperty
    a_select_source: assert property (p_select_source)
        else $error("counter moved without a tick of the chosen source");

    property p_flag_read_only;
        @(posedge clk) disable iff (!rst_b || !pin_rst_b)
        (ctrl_wr && !fire) |=> $stable(reset_source_flag);
    endproperty
    a_flag_read_only: assert property (p_flag_read_only)
        else $error("software write changed the reset source flag");

    // the next interval after an underflow starts from the top
    property p_wrap;
        @(posedge clk) disable iff (!rst_b)
        underflow |=> (watchdog_counter == ~CNT_ZERO);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("counter did not wrap to ff at underflow");
endmodule
`default_nettype wire

// File: watchdog_interval_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module watchdog_interval_timer_tb;
    import wdt_pkg::*;
    logic        clk;
    logic        rst_b;
    logic        pin_rst_b;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        slow_all;
    logic        slow_peri;
    logic        irq_ack;
    logic        irq;
    logic        chip_reset_req;
    logic [31:0] rd;
    logic        err;
    int          miscompares;
    int          n_checks;
    int          n_rr;
    int          w;

    watchdog_interval_timer #(.DIV_SRC0(2), .DIV_SRC1(3), .DIV_SRC2(4),
        .DIV_SRC3(5), .CHIP_RESET_LEN(2)) watchdog_interval_timer_inst (
        .clk(clk), .rst_b(rst_b), .pin_rst_b(pin_rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .all_slow_power_mode(slow_all),
        .peripheral_slow_power_mode(slow_peri), .irq_ack(irq_ack),
        .irq(irq), .chip_reset_req(chip_reset_req));

    always #5 clk = ~clk;

    // count request cycles so scenarios can tell whether one was raised
    always @(posedge clk) begin
        if (chip_reset_req === 1'b1) n_rr++;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // range compare: tick phase leaves up to one period of slack
    task automatic chk_rng(input logic [7:0] got, input int lo, input int hi);
        n_checks++;
        if (!(got >= lo && got <= hi) || $isunknown(got)) begin
            miscompares++;
            $display("MISMATCH t=%0t got %0d range %0d..%0d", $time, got,
                     lo, hi);
        end
    endtask

    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    function automatic logic [31:0] cfg(input logic [1:0] on, ren, sel);
        return {24'h0, on, ren, 2'b00, sel};
    endfunction

    task automatic do_reset(input logic pin);
        @(posedge clk);
        rst_b <= 1'b0;
        pin_rst_b <= ~pin;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        pin_rst_b <= 1'b1;
    endtask

    // run from ff for about 62 cycles, then freeze and read the decrement
    task automatic measure(input logic [1:0] on, sel, input int n);
        wr_reg(CNT_OFS, 32'hff);
        wr_reg(CTRL_OFS, cfg(on, 2'h1, sel));
        repeat (60) @(posedge clk);
        wr_reg(CTRL_OFS, cfg(2'h1, 2'h1, sel));
        apb(1'b0, CNT_OFS, 32'h0);
        chk_rng(8'hff - rd[7:0], n - 1, n + 2);
    endtask

    // bounded wait for a design output; a miss returns with w at lim for the caller to check
    task automatic wait_for(input int which, input int lim);
        w = 0;
        while ((which ? chip_reset_req : irq) !== 1'b1 && w < lim) begin
            @(posedge clk);
            w++;
        end
    endtask

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        pin_rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        slow_all = 1'b0;
        slow_peri = 1'b0;
        irq_ack = 1'b0;
        miscompares = 0;
        n_checks = 0;
        n_rr = 0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        pin_rst_b <= 1'b1;
        rd_chk(CTRL_OFS, 32'h50);
        rd_chk(CNT_OFS, 32'hff);
        rd_chk(IRQ_EN_OFS, 32'h0);
        rd_chk(8'h14, 32'h0);
        chk({31'h0, err}, 32'h1);
        wr_reg(CTRL_OFS, 32'h5c);
        rd_chk(CTRL_OFS, 32'h50);
        repeat (20) @(posedge clk);
        rd_chk(CNT_OFS, 32'hff);
        $display("test reset and freeze done");
        for (int s = 0; s < 4; s++) begin
            measure(2'h2, s[1:0], 62 / (s + 2));
        end
        measure(2'h0, 2'h0, 31);
        measure(2'h3, 2'h0, 31);
        slow_all <= 1'b1;
        measure(2'h2, 2'h0, 62 / SLOW_DIV);
        slow_all <= 1'b0;
        slow_peri <= 1'b1;
        measure(2'h2, 2'h3, 62 / SLOW_DIV);
        slow_peri <= 1'b0;
        $display("test clock select done");
        wr_reg(CNT_OFS, 32'h10);
        wr_reg(CTRL_OFS, cfg(2'h2, 2'h1, 2'h0));
        repeat (5) begin
            repeat (15) @(posedge clk);
            wr_reg(CNT_OFS, 32'h10);
        end
        rd_chk(IRQ_STAT_OFS, 32'h0);
        $display("test reload done");
        wr_reg(IRQ_EN_OFS, 32'h1);
        for (int k = 0; k < 2; k++) begin
            // run first, so the load edge starts the interval in both passes
            wr_reg(CTRL_OFS, cfg(2'h2, 2'h1, 2'h0));
            wr_reg(CNT_OFS, 32'h3);
            wait_for(0, 100);
            // (3+1)*2 edges less under one tick, one more to see irq
            chk_rng(w[7:0], 8, 9);
            wr_reg(CTRL_OFS, cfg(2'h1, 2'h1, 2'h0));
            rd_chk(IRQ_STAT_OFS, 32'h1);
            if (k == 0) begin
                wr_reg(IRQ_EN_OFS, 32'h0);
                // irq is a flop fed by the old enable at the write edge
                repeat (2) @(posedge clk);
                chk({31'h0, irq}, 32'h0);
                wr_reg(IRQ_CLR_OFS, 32'h1);
                wr_reg(IRQ_EN_OFS, 32'h1);
            end else begin
                irq_ack <= 1'b1;
                @(posedge clk);
                irq_ack <= 1'b0;
                @(posedge clk);
            end
            rd_chk(IRQ_STAT_OFS, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        chk(n_rr, 0);
        $display("test interval mode done");
        for (int c = 0; c < 4; c++) begin
            if (c == 1) continue;
            // pin reset first so each pass must set the flag itself
            do_reset(1'b1);
            wr_reg(CNT_OFS, 32'h2);
            wr_reg(CTRL_OFS, cfg(2'h2, c[1:0], 2'h0));
            wait_for(1, 100);
            chk({31'h0, chip_reset_req}, 32'h1);
            rd_chk(IRQ_STAT_OFS, 32'h1);
            do_reset(1'b0);
            rd_chk(CTRL_OFS, 32'h58);
            rd_chk(CNT_OFS, 32'hff);
        end
        do_reset(1'b1);
        rd_chk(CTRL_OFS, 32'h50);
        $display("test reset generation done");
        conclude();
    end

    // the run needs under a thousand cycles; this is far beyond that
    initial begin
        #200000;
        miscompares++;
        conclude();
    end
endmodule
`default_nettype wire

// File: wdt_pkg.sv
`default_nettype none
package wdt_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] CNT_OFS       = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS  = 8'h08;
    localparam logic [7:0] IRQ_CLR_OFS   = 8'h0c;
    localparam logic [7:0] IRQ_EN_OFS    = 8'h10;

    // control register field positions
    localparam int TURN_ON_LSB   = 6;
    localparam int RESET_EN_LSB  = 4;
    localparam int SRC_FLAG_BIT  = 3;
    localparam int RSVD_BIT      = 2;
    localparam int CLK_SEL_LSB   = 0;

    // reset values and the one code that means off
    localparam logic [1:0] TURN_ON_RST   = 2'h1;
    localparam logic [1:0] RESET_EN_RST  = 2'h1;
    localparam logic [1:0] CLK_SEL_RST   = 2'h0;
    localparam logic [1:0] FIELD_OFF     = 2'h1;
    localparam logic [7:0] CNT_RST       = 8'hff;
    localparam logic [7:0] CNT_ZERO      = 8'h00;
    localparam int         IRQ_BITS      = 1;
    localparam logic [IRQ_BITS-1:0] IRQ_EN_RST = 1'h0;

    // timing
    localparam int SYS_CLK_PERIOD_NS = 10;
    localparam int SLOW_DIV          = 12;
    localparam int CHIP_RESET_NS     = 100;
    localparam int CHIP_RESET_CYCLES =
        (CHIP_RESET_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

    typedef enum logic [0:0] {
        WD_IDLE = 1'b0,
        WD_FIRE = 1'b1
    } fire_state_t;
endpackage
`default_nettype wire
